// ==== core/ppl_ctrl.sv ====
// port pull-up, key return and output latch control with ahb-lite access
//
// Contract
// - pull-up only on input bits whose port pull-up enable is set
// - no pull-up on output bits or analog inputs, whatever the enable
// - both pull-up enable registers take bit or byte writes, reset to zero (the code takes whole-byte writes only)
// - port 0 bits 0 and 7 never get a pull-up
// - ports 1, 8, 9 in alternate function get no pull-up
// - high register bits 0-3 ports 8-11; low bits 0-3 ports 0-3, 7 port 7
// - key mode register enables wake and selects port 11 edges; reset 02
// - key edge flag is cleared only by software
// - output mode write updates latch and drives pin until next write
// - input mode write updates latch, pin stays undriven
// - single-bit operation rewrites the whole port byte
// - output bit read returns latch, latch unchanged
// - input bit read returns pin level, latch unchanged
// - read-modify-write in output mode works on latch and drives pins
// - direction bit 0 output, 1 input; reset sets all ones
// - falling edge on any port 11 pin sets key edge flag while key mode select bit 1 is set
`timescale 1ns/1ps
module ppl_ctrl
    import ppl_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [NSLOT*8-1:0]   port_pin_in,
    output logic      [NSLOT*8-1:0]   port_pin_out,
    output logic      [NSLOT*8-1:0]   port_pin_oe_b,
    output logic      [NSLOT*8-1:0]   port_pullup_on,
    output logic                      key_wake
);
    typedef struct packed {
        ppl_bus_type      bus;
        logic [IDX_W-1:0] idx;
        logic             hit;
        logic [7:0]       pu_high;
        logic [7:0]       pu_low;
        logic [7:0]       key_mode;
        logic             key_flag;
        logic [7:0]       alt;
        logic [7:0]       key_prev;
        logic [31:0]      rdata;
    } ppl_ctrl_type;

    ppl_ctrl_type st_ff;
    ppl_ctrl_type nxt_st;

    logic [NSLOT-1:0]      wr_latch;
    logic [NSLOT-1:0]      wr_dir;
    logic [NSLOT-1:0][7:0] wbyte;
    logic [NSLOT-1:0]      pull_en;
    logic [NSLOT-1:0]      alt_on;
    logic [NSLOT-1:0][7:0] rd_arr;
    logic [NSLOT-1:0][7:0] latch_arr;
    logic [NSLOT-1:0][7:0] dir_arr;
    logic [7:0]            pin11;
    logic [7:0]            fall11;
    logic                  key_set;
    logic                  wr_phase;
    logic                  take;
    logic [3:0]            op_slot;
    logic [2:0]            op_bit;
    logic [7:0]            op_byte;
    logic [IDX_W-1:0]      lat_off;
    logic [IDX_W-1:0]      dir_off;

    ////////////////////////////////////////////////////////////////////
    // port slices
    for (genvar i = 0; i < NSLOT; i++) begin : g_port
        ppl_port_if pif ();
        assign pif.wr_latch = wr_latch[i];
        assign pif.wr_dir   = wr_dir[i];
        assign pif.wdata    = wbyte[i];
        assign pif.pull_en  = pull_en[i];
        assign pif.alt_on   = alt_on[i];
        assign rd_arr[i]    = pif.rd_value;
        assign latch_arr[i] = pif.latch;
        assign dir_arr[i]   = pif.dir;
        ppl_port #(
            .FIXED_IN ((i == 0) ? P0_INPUT_ONLY : MASK_NONE),
            .NO_PULL  ((i == 0) ? P0_INPUT_ONLY : MASK_NONE)
        ) u_port (
            .clock     (clock),
            .rst_b     (rst_b),
            .pif       (pif),
            .pin_in    (port_pin_in[i*8 +: 8]),
            .pin_out   (port_pin_out[i*8 +: 8]),
            .pin_oe_b  (port_pin_oe_b[i*8 +: 8]),
            .pullup_on (port_pullup_on[i*8 +: 8])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // pull-up enable and alternate function per slot
    always_comb begin
        for (int s = 0; s < 4; s++) begin
            pull_en[s] = st_ff.pu_low[s];
        end
        pull_en[SLOT_P7] = st_ff.pu_low[7];
        for (int s = 0; s < 4; s++) begin
            pull_en[SLOT_P8 + s] = st_ff.pu_high[s];
        end
        alt_on              = '0;
        alt_on[SLOT_P1]     = st_ff.alt[ALT_P1_BIT];
        alt_on[SLOT_P8]     = st_ff.alt[ALT_P8_BIT];
        alt_on[SLOT_P9]     = st_ff.alt[ALT_P9_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // key return edge detect on port 11
    assign pin11   = port_pin_in[SLOT_P11*8 +: 8];
    assign fall11  = st_ff.key_prev & ~pin11;
    assign key_set = st_ff.key_mode[KEY_SEL_BIT] & (|fall11);
    assign key_wake = st_ff.key_mode[KEY_WAKE_BIT] & st_ff.key_flag;

    ////////////////////////////////////////////////////////////////////
    // bus handshake
    assign take      = hsel & htrans[1] & hready & hreadyout;
    assign wr_phase  = (st_ff.bus == BUS_WRITE) & st_ff.hit;
    assign hreadyout = (st_ff.bus != BUS_READ);
    assign hresp     = 1'b0;
    assign hrdata    = st_ff.rdata;

    assign op_slot = hwdata[BITOP_SLOT_LSB +: 4];
    assign op_bit  = hwdata[BITOP_BIT_LSB +: 3];
    assign lat_off = st_ff.idx - IDX_LATCH_BASE;
    assign dir_off = st_ff.idx - IDX_DIR_BASE;

    // single-bit operation reads the whole port and writes the byte back
    always_comb begin
        op_byte = LATCH_RST;
        for (int s = 0; s < NSLOT; s++) begin
            if (op_slot == 4'(s)) begin
                op_byte = rd_arr[s];
            end
        end
        op_byte[op_bit] = hwdata[BITOP_VAL_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st       = st_ff;
        wr_latch     = '0;
        wr_dir       = '0;
        nxt_st.key_prev = pin11;
        for (int s = 0; s < NSLOT; s++) begin
            wbyte[s] = hwdata[7:0];
        end
        // data phase writes
        if (wr_phase) begin
            unique case (st_ff.idx)
                IDX_PU_HIGH:  nxt_st.pu_high  = hwdata[7:0];
                IDX_PU_LOW:   nxt_st.pu_low   = hwdata[7:0];
                IDX_KEY_MODE: nxt_st.key_mode = hwdata[7:0];
                IDX_KEY_FLAG: nxt_st.key_flag = hwdata[0];
                IDX_ALT:      nxt_st.alt      = hwdata[7:0];
                IDX_BIT_OP: begin
                    for (int s = 0; s < NSLOT; s++) begin
                        if (op_slot == 4'(s)) begin
                            wr_latch[s] = 1'b1;
                            wbyte[s]    = op_byte;
                        end
                    end
                end
                default: begin
                    if (lat_off < IDX_W'(NSLOT)) begin
                        wr_latch[lat_off[3:0]] = 1'b1;
                    end else if (dir_off < IDX_W'(NSLOT)) begin
                        wr_dir[dir_off[3:0]] = 1'b1;
                    end
                end
            endcase
        end
        // hardware set wins over the software clear
        if (key_set) begin
            nxt_st.key_flag = 1'b1;
        end
        // read data is built in the wait cycle
        if (st_ff.bus == BUS_READ) begin
            nxt_st.rdata = WORD_ZERO;
            if (st_ff.hit) begin
                unique case (st_ff.idx)
                    IDX_PU_HIGH:  nxt_st.rdata[7:0] = st_ff.pu_high;
                    IDX_PU_LOW:   nxt_st.rdata[7:0] = st_ff.pu_low;
                    IDX_KEY_MODE: nxt_st.rdata[7:0] = st_ff.key_mode;
                    IDX_KEY_FLAG: nxt_st.rdata[0]   = st_ff.key_flag;
                    IDX_ALT:      nxt_st.rdata[7:0] = st_ff.alt;
                    default: begin
                        if (lat_off < IDX_W'(NSLOT)) begin
                            nxt_st.rdata[7:0] = rd_arr[lat_off[3:0]];
                        end else if (dir_off < IDX_W'(NSLOT)) begin
                            nxt_st.rdata[7:0] = dir_arr[dir_off[3:0]];
                        end
                    end
                endcase
            end
        end
        // bus sequencing
        unique case (st_ff.bus)
            BUS_READ: nxt_st.bus = BUS_RDONE;
            BUS_IDLE, BUS_WRITE, BUS_RDONE: begin
                if (take) begin
                    nxt_st.idx = haddr[IDX_W+1:2];
                    nxt_st.hit = (haddr[31:IDX_W+2] == '0);
                    nxt_st.bus = hwrite ? BUS_WRITE : BUS_READ;
                end else begin
                    nxt_st.bus = BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_ff <= '{bus: BUS_IDLE, idx: '0, hit: 1'b0,
                       pu_high: PU_RST, pu_low: PU_RST,
                       key_mode: KEY_MODE_RST, key_flag: 1'b0,
                       alt: ALT_RST, key_prev: '0, rdata: WORD_ZERO};
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    chk_pull_only_input: assert property (
        (port_pullup_on & ~port_pin_oe_b) == '0)
        else $error("pull-up on a driven bit");

    chk_pull_p0_fixed: assert property (
        (port_pullup_on[7:0] & P0_INPUT_ONLY) == MASK_NONE)
        else $error("pull-up on port 0 input-only bit");

    chk_pull_alt_off: assert property (
        st_ff.alt[ALT_P8_BIT] |-> port_pullup_on[SLOT_P8*8 +: 8] == '0)
        else $error("pull-up on port 8 in alternate function");

    chk_pull_follows_en: assert property (
        port_pullup_on[(SLOT_P8+2)*8 +: 8] ==
        ({8{st_ff.pu_high[2]}} & port_pin_oe_b[(SLOT_P8+2)*8 +: 8]))
        else $error("port 10 pull-up does not follow enable");

    chk_reset_values: assert property (
        $rose(rst_b) |-> st_ff.pu_high == PU_RST && st_ff.pu_low == PU_RST
        && st_ff.key_mode == KEY_MODE_RST && dir_arr[SLOT_P11] == DIR_RST)
        else $error("register not at reset value");

    chk_flag_sets: assert property (
        key_set |=> st_ff.key_flag)
        else $error("falling edge did not set key flag");

    chk_flag_holds: assert property (
        st_ff.key_flag && !(wr_phase && st_ff.idx == IDX_KEY_FLAG)
        |=> st_ff.key_flag)
        else $error("key flag cleared without software");

    chk_latch_drives: assert property (
        wr_latch[SLOT_P11] |=> port_pin_out[SLOT_P11*8 +: 8]
        == $past(wbyte[SLOT_P11]))
        else $error("written latch value not on pins");

    chk_read_answer: assert property (
        st_ff.bus == BUS_READ && st_ff.hit
        && st_ff.idx == IDX_LATCH_BASE + 16'h0003
        |=> hreadyout && hrdata[7:0] == $past(rd_arr[3]))
        else $error("port read returned wrong value");

    chk_bitop_byte: assert property (
        wr_phase && st_ff.idx == IDX_BIT_OP && op_slot == 4'h3
        |=> latch_arr[3][$past(op_bit)]
        == $past(hwdata[BITOP_VAL_BIT]))
        else $error("bit operation did not land");

    cov_key_flag: cover property (key_set ##1 key_wake);
    cov_bitop: cover property (wr_phase && st_ff.idx == IDX_BIT_OP);
    cov_read_done: cover property (st_ff.bus == BUS_READ ##1 hreadyout);
endmodule : ppl_ctrl

// ==== core/ppl_pkg.sv ====
// constants shared by the port pull-up and latch control block
package ppl_pkg;
    localparam int          NSLOT          = 9;
    localparam int          IDX_W          = 16;
    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_PU_HIGH    = 16'hfff3;
    localparam logic [15:0] IDX_PU_LOW     = 16'hfff7;
    localparam logic [15:0] IDX_KEY_MODE   = 16'hfff8;
    localparam logic [15:0] IDX_KEY_FLAG   = 16'hfff9;
    localparam logic [15:0] IDX_ALT        = 16'hfffa;
    localparam logic [15:0] IDX_BIT_OP     = 16'hfffb;
    localparam logic [15:0] IDX_LATCH_BASE = 16'hff00;
    localparam logic [15:0] IDX_DIR_BASE   = 16'hff20;
    // reset values
    localparam logic [7:0]  PU_RST         = 8'h00;
    localparam logic [7:0]  KEY_MODE_RST   = 8'h02;
    localparam logic [7:0]  DIR_RST        = 8'hff;
    localparam logic [7:0]  LATCH_RST      = 8'h00;
    localparam logic [7:0]  ALT_RST        = 8'h00;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
    // field positions
    localparam int          KEY_WAKE_BIT   = 0;
    localparam int          KEY_SEL_BIT    = 1;
    localparam int          ALT_P1_BIT     = 0;
    localparam int          ALT_P8_BIT     = 1;
    localparam int          ALT_P9_BIT     = 2;
    localparam int          BITOP_SLOT_LSB = 0;
    localparam int          BITOP_BIT_LSB  = 4;
    localparam int          BITOP_VAL_BIT  = 7;
    // slot numbers of ports 1, 7, 8, 9, 11 and port 0 bit masks
    localparam int          SLOT_P1        = 1;
    localparam int          SLOT_P7        = 4;
    localparam int          SLOT_P8        = 5;
    localparam int          SLOT_P9        = 6;
    localparam int          SLOT_P11       = 8;
    localparam logic [7:0]  P0_INPUT_ONLY  = 8'h81;
    localparam logic [7:0]  MASK_NONE      = 8'h00;
    typedef enum logic [3:0] {
        BUS_IDLE  = 4'b0001,
        BUS_WRITE = 4'b0010,
        BUS_READ  = 4'b0100,
        BUS_RDONE = 4'b1000
    } ppl_bus_type;
endpackage : ppl_pkg

// ==== core/ppl_port.sv ====
// one 8-bit port slice: output latch, direction, pin and pull-up
`timescale 1ns/1ps
module ppl_port
    import ppl_pkg::*;
#(
    parameter logic [7:0] FIXED_IN = 8'h00,
    parameter logic [7:0] NO_PULL  = 8'h00
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    ppl_port_if.port        pif,
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe_b,
    output logic      [7:0] pullup_on
);
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
    } ppl_slice_type;

    ppl_slice_type st_ff;
    ppl_slice_type nxt_st;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        if (pif.wr_latch) begin
            nxt_st.latch = pif.wdata;
        end
        if (pif.wr_dir) begin
            nxt_st.dir = pif.wdata | FIXED_IN;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_ff <= '{latch: LATCH_RST, dir: DIR_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output buffer on only where the bit is an output
    assign pin_out      = st_ff.latch;
    assign pin_oe_b     = st_ff.dir;
    assign pullup_on    = {8{pif.pull_en & ~pif.alt_on}} & st_ff.dir
                          & ~NO_PULL;
    assign pif.rd_value = (st_ff.dir & pin_in)
                          | (~st_ff.dir & st_ff.latch);
    assign pif.latch    = st_ff.latch;
    assign pif.dir      = st_ff.dir;

    ////////////////////////////////////////////////////////////////////
    chk_latch_kept: assert property (@(posedge clock) disable iff (!rst_b)
        !pif.wr_latch |=> st_ff.latch == $past(st_ff.latch))
        else $error("latch changed without a write");
endmodule : ppl_port

// ==== core/ppl_port_if.sv ====
// control bundle between the register file and one port slice
`timescale 1ns/1ps
interface ppl_port_if;
    logic       wr_latch;
    logic       wr_dir;
    logic [7:0] wdata;
    logic       pull_en;
    logic       alt_on;
    logic [7:0] rd_value;
    logic [7:0] latch;
    logic [7:0] dir;
    modport ctrl (output wr_latch, wr_dir, wdata, pull_en, alt_on,
                  input  rd_value, latch, dir);
    modport port (input  wr_latch, wr_dir, wdata, pull_en, alt_on,
                  output rd_value, latch, dir);
endinterface : ppl_port_if

// ==== dv/port_pullup_and_latch_control_test.sv ====
// self-checking bench for the port pull-up and latch control block
`timescale 1ns/1ps
module port_pullup_and_latch_control_test
    import ppl_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = WORD_ZERO;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = WORD_ZERO;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        key_wake;
    logic [71:0] pin_in, pin_out, oe_b, pull;
    logic [71:0] ext_en = {8'hff, 64'h0};
    logic [71:0] ext_val = {8'hff, 64'h0};
    int          bad_count = 0;
    int          comparisons = 0;

    always #12.5 clock = ~clock;

    ppl_ctrl dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .port_pin_in(pin_in), .port_pin_out(pin_out),
        .port_pin_oe_b(oe_b), .port_pullup_on(pull), .key_wake(key_wake));

    ppl_pin_model pins (.clock(clock), .pin_out(pin_out), .pin_oe_b(oe_b),
        .pullup_on(pull), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input string nm, input logic [71:0] exp,
                       input logic [71:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    task automatic wait_rdy(output logic [31:0] rd);
        int n;
        n = 0;
        // sample at the rising edge, before the design's registers move
        do begin
            @(posedge clock);
            rd = hrdata;
            n++;
        end while (hready !== 1'b1 && n < 30);
        if (n >= 30) bad_count++;
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy(rd);
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        wait_rdy(rd);
    endtask : bus

    task automatic wreg(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, idx, d, rd);
        @(negedge clock);
    endtask : wreg

    task automatic rchk(input string nm, input logic [15:0] idx,
                        input logic [7:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 8'h00, rd);
        cmp(nm, {64'h0, exp}, {40'h0, rd});
    endtask : rchk

    function automatic logic [7:0] sl(input logic [71:0] v, input int s);
        return v[s*8 +: 8];
    endfunction : sl

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rchk("pu_high", IDX_PU_HIGH, 8'h00);
        rchk("pu_low", IDX_PU_LOW, 8'h00);
        rchk("key_mode", IDX_KEY_MODE, 8'h02);
        rchk("key_flag", IDX_KEY_FLAG, 8'h00);
        rchk("dir1", IDX_DIR_BASE + 16'h0001, 8'hff);
        rchk("unmapped", 16'h1234, 8'h00);
        cmp("pull", 72'h0, pull);
        cmp("oe_b", {72{1'b1}}, oe_b);
        cmp("hresp", 72'h0, {71'h0, hresp});
    endtask : t_reset

    task automatic t_pullup;
        wreg(IDX_PU_LOW, 8'h8f);
        wreg(IDX_PU_HIGH, 8'h05);
        cmp("pull_a", {8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff,
            8'hff, 8'h7e}, pull);
        rchk("pu_low", IDX_PU_LOW, 8'h8f);
        wreg(IDX_DIR_BASE + 16'h0002, 8'h0f);
        wreg(IDX_ALT, 8'h07);
        cmp("pull_b", {8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h0f,
            8'h00, 8'h7e}, pull);
    endtask : t_pullup

    task automatic t_latch;
        wreg(IDX_DIR_BASE + 16'h0003, 8'h00);
        wreg(IDX_LATCH_BASE + 16'h0003, 8'ha5);
        cmp("out3", 72'ha5, sl(pin_out, 3));
        cmp("oe3", 72'h00, sl(oe_b, 3));
        rchk("rd3", IDX_LATCH_BASE + 16'h0003, 8'ha5);
        wreg(IDX_LATCH_BASE + 16'h0007, 8'h3c);
        cmp("out7", 72'h3c, sl(pin_out, 7));
        cmp("oe7", 72'hff, sl(oe_b, 7));
        @(posedge clock);
        ext_en[63:56] <= 8'hff;
        ext_val[63:56] <= 8'h5a;
        rchk("rd7", IDX_LATCH_BASE + 16'h0007, 8'h5a);
        cmp("hold7", 72'h3c, sl(pin_out, 7));
        wreg(IDX_BIT_OP, 8'h93);
        cmp("bit3", 72'ha7, sl(pin_out, 3));
        rchk("rd3b", IDX_LATCH_BASE + 16'h0003, 8'ha7);
        wreg(IDX_DIR_BASE + 16'h0007, 8'h0f);
        wreg(IDX_BIT_OP, 8'h27);
        cmp("bit7", 72'ha, {68'h0, pin_out[59:56]});
    endtask : t_latch

    task automatic edge11(input logic [7:0] lvl);
        @(posedge clock);
        ext_val[71:64] <= lvl;
        repeat (3) @(posedge clock);
    endtask : edge11

    task automatic t_key;
        edge11(8'h00);
        rchk("flag_set", IDX_KEY_FLAG, 8'h01);
        repeat (5) @(posedge clock);
        rchk("flag_kept", IDX_KEY_FLAG, 8'h01);
        cmp("wake_off", 72'h0, {71'h0, key_wake});
        wreg(IDX_KEY_MODE, 8'h03);
        cmp("wake_on", 72'h1, {71'h0, key_wake});
        wreg(IDX_KEY_FLAG, 8'h00);
        rchk("flag_clr", IDX_KEY_FLAG, 8'h00);
        cmp("wake_clr", 72'h0, {71'h0, key_wake});
        wreg(IDX_KEY_MODE, 8'h01);
        edge11(8'hff);
        edge11(8'h00);
        rchk("flag_nosel", IDX_KEY_FLAG, 8'h00);
    endtask : t_key

    ////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial begin
        #(25ns * 20000);
        bad_count++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_pullup();
        t_latch();
        t_key();
        conclude();
    end
endmodule : port_pullup_and_latch_control_test

// ==== dv/ppl_pin_model.sv ====
// external pin and key line model for the port control block
`timescale 1ns/1ps
module ppl_pin_model
    import ppl_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic [NSLOT*8-1:0]   pin_out,
    input  wire logic [NSLOT*8-1:0]   pin_oe_b,
    input  wire logic [NSLOT*8-1:0]   pullup_on,
    input  wire logic [NSLOT*8-1:0]   ext_en,
    input  wire logic [NSLOT*8-1:0]   ext_val,
    output logic      [NSLOT*8-1:0]   pin_in
);
    logic flt_ff = 1'b0;

    // a floating line with nothing on it shows a level that keeps moving
    always_ff @(posedge clock) begin
        flt_ff <= ~flt_ff;
    end

    always_comb begin
        for (int i = 0; i < NSLOT*8; i++) begin
            if (!pin_oe_b[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pullup_on[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = flt_ff ^ i[0];
        end
    end
endmodule : ppl_pin_model
